/* rtl/tcf_pkg.sv */
// Constants, types and register map of the timer capture/compare flag channel
package tcf_pkg;
    // Register indices; byte address is four times the index
    localparam logic [23:0] IDX_IO_CONTROL_HIGH = 24'hFFFFF2;
    localparam logic [23:0] IDX_CHANNEL_STATUS_FLAGS = 24'hFFFFF5;
    localparam logic [23:0] IDX_COUNTER_CONTROL = 24'hFFFFF0;
    localparam logic [23:0] IDX_REQUEST_ENABLE = 24'hFFFFF4;
    localparam logic [23:0] IDX_CHANNEL_COUNTER = 24'hFFFFF6;
    localparam logic [23:0] IDX_GENERAL_REG_A = 24'hFFFFF8;
    localparam logic [23:0] IDX_GENERAL_REG_B = 24'hFFFFF9;
    localparam logic [23:0] IDX_GENERAL_REG_C = 24'hFFFFFA;
    // Field positions
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_B_BIT = 1;
    localparam int FLAG_C_BIT = 2;
    localparam int RUN_BIT = 0;
    localparam int CLEAR_SEL_LSB = 5;
    // Mode codes
    localparam logic [3:0] PIN_B_OUTPUT_OFF = 4'h0;
    localparam logic [3:0] PIN_A_CAPTURE_FALL = 4'h9;
    localparam logic [3:0] PIN_A_CAPTURE_RISE = 4'h8;
    localparam logic [2:0] CLEAR_BY_REG_A = 3'h1;
    // Reset values
    localparam logic [7:0] IO_CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [2:0] ENABLE_RESET = 3'h0;
    localparam logic [15:0] GENERAL_REG_RESET = 16'hFFFF;

    typedef struct packed {
        logic [3:0] pin_b_mode_field;
        logic [3:0] pin_a_mode_field;
    } tcf_io_control_t;

    typedef struct packed {
        tcf_io_control_t io_control_high;
        logic [7:0] counter_control;
        logic [2:0] request_enable;
        logic [2:0] channel_status_flags;
        logic [2:0] read_as_one;
        logic [15:0] channel_counter;
        logic [15:0] general_reg_a;
        logic [15:0] general_reg_b;
        logic [15:0] general_reg_c;
        logic cap_level;
        logic pin_b_level;
    } tcf_state_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic capture_request_a;
        logic compare_request_c;
        logic pin_b_out;
        logic pin_b_oe;
    } tcf_outputs_t;
endpackage

/* rtl/tcf_channel.sv */
// Timer channel with capture A, compare B and C, status flags and APB registers
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module tcf_channel
    import tcf_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_compare_pin_b_in,
    output logic capture_compare_pin_b_out,
    output logic capture_compare_pin_b_oe,
    input wire logic dma_start_a,
    input wire logic dma_flag_clear_enable,
    output logic capture_request_a,
    output logic compare_request_c,
    output logic irq
);
    tcf_state_t st_q;
    tcf_state_t st_d;
    tcf_outputs_t out_q;
    tcf_outputs_t out_d;

    function automatic logic [31:0] byte_addr(input logic [23:0] idx);
        byte_addr = {6'h00, idx, 2'b00};
    endfunction

    function automatic logic hit(input logic [31:0] addr, input logic [23:0] idx);
        hit = (addr == byte_addr(idx));
    endfunction

    function automatic logic mapped(input logic [31:0] addr);
        mapped = hit(addr, IDX_IO_CONTROL_HIGH) | hit(addr, IDX_CHANNEL_STATUS_FLAGS)
            | hit(addr, IDX_COUNTER_CONTROL) | hit(addr, IDX_REQUEST_ENABLE)
            | hit(addr, IDX_CHANNEL_COUNTER) | hit(addr, IDX_GENERAL_REG_A)
            | hit(addr, IDX_GENERAL_REG_B) | hit(addr, IDX_GENERAL_REG_C);
    endfunction

    logic access;
    logic done;
    logic wr;
    logic rd;
    logic capture_mode_a;
    logic cap_fall;
    logic cap_rise;
    logic capture_a;
    logic match_a;
    logic match_b;
    logic match_c;
    logic [2:0] hw_set;
    logic [2:0] sw_clear;
    logic [2:0] flags_next;
    logic [3:0] b_mode;
    logic [COUNT_WIDTH-1:0] cnt;

    always_comb
    begin
        st_d = st_q;
        out_d = out_q;
        access = psel & penable;
        done = access & out_q.pready;
        wr = done & pwrite & ~out_q.pslverr;
        rd = done & ~pwrite & ~out_q.pslverr;
        b_mode = st_q.io_control_high.pin_b_mode_field;
        cnt = st_q.channel_counter[COUNT_WIDTH-1:0];

        // Inputs are synchronous, so one stored sample suffices for edges
        st_d.cap_level = capture_compare_pin_b_in;
        cap_fall = st_q.cap_level & ~capture_compare_pin_b_in;
        cap_rise = ~st_q.cap_level & capture_compare_pin_b_in;
        capture_mode_a = st_q.io_control_high.pin_a_mode_field[3];
        capture_a = 1'b0;
        if (st_q.io_control_high.pin_a_mode_field == PIN_A_CAPTURE_FALL)
        begin
            capture_a = cap_fall;
        end
        else if (st_q.io_control_high.pin_a_mode_field == PIN_A_CAPTURE_RISE)
        begin
            capture_a = cap_rise;
        end
        else if (capture_mode_a)
        begin
            capture_a = cap_fall | cap_rise;
        end
        match_a = ~capture_mode_a & (cnt == st_q.general_reg_a[COUNT_WIDTH-1:0]);
        match_b = (cnt == st_q.general_reg_b[COUNT_WIDTH-1:0]);
        match_c = (cnt == st_q.general_reg_c[COUNT_WIDTH-1:0]);

        // Counter and capture transfer
        if (capture_a)
        begin
            st_d.general_reg_a = st_q.channel_counter;
        end
        // A capture clears even a stopped counter; a match only counts while running
        if ((capture_a | (match_a & st_q.counter_control[RUN_BIT]))
            && st_q.counter_control[CLEAR_SEL_LSB +: 3] == CLEAR_BY_REG_A)
        begin
            st_d.channel_counter = '0;
        end
        else if (st_q.counter_control[RUN_BIT])
        begin
            st_d.channel_counter = st_q.channel_counter + 16'h0001;
        end

        // Compare output B: bit 2 is the idle level, bits 1..0 the match action
        if (b_mode != PIN_B_OUTPUT_OFF && st_q.counter_control[RUN_BIT] && match_b)
        begin
            case (b_mode[1:0])
                2'h1: st_d.pin_b_level = 1'b0;
                2'h2: st_d.pin_b_level = 1'b1;
                2'h3: st_d.pin_b_level = ~st_q.pin_b_level;
                default: st_d.pin_b_level = st_q.pin_b_level;
            endcase
        end
        out_d.pin_b_oe = (b_mode != PIN_B_OUTPUT_OFF) & ~b_mode[3];
        out_d.pin_b_out = out_d.pin_b_oe & st_d.pin_b_level;

        // Status flags: hardware set, software clear after a read of one
        hw_set = '0;
        hw_set[FLAG_A_BIT] = capture_a;
        hw_set[FLAG_B_BIT] = match_b & st_q.counter_control[RUN_BIT];
        hw_set[FLAG_C_BIT] = match_c & st_q.counter_control[RUN_BIT];
        sw_clear = '0;
        if (wr && pstrb[0] && hit(paddr, IDX_CHANNEL_STATUS_FLAGS))
        begin
            sw_clear = ~pwdata[2:0] & st_q.read_as_one;
            st_d.read_as_one = st_q.read_as_one & ~sw_clear;
        end
        if (dma_start_a && dma_flag_clear_enable)
        begin
            sw_clear[FLAG_A_BIT] = 1'b1;
        end
        // Only a clear can come from outside; a written one is ignored
        flags_next = (st_q.channel_status_flags & ~sw_clear) | hw_set;
        st_d.channel_status_flags = flags_next;
        if (rd && hit(paddr, IDX_CHANNEL_STATUS_FLAGS))
        begin
            // Arm only what software saw; a flag set after the data was latched stays unarmed
            st_d.read_as_one = st_q.read_as_one | out_q.prdata[2:0];
        end
        // A dropped flag needs a fresh read of one before a zero write counts
        st_d.read_as_one = st_d.read_as_one & flags_next;

        // Configuration writes
        if (wr && pstrb[0])
        begin
            if (hit(paddr, IDX_IO_CONTROL_HIGH))
            begin
                st_d.io_control_high = pwdata[7:0];
                st_d.pin_b_level = pwdata[6];
            end
            if (hit(paddr, IDX_COUNTER_CONTROL))
            begin
                st_d.counter_control = pwdata[7:0];
            end
            if (hit(paddr, IDX_REQUEST_ENABLE))
            begin
                st_d.request_enable = pwdata[2:0];
            end
        end
        if (wr && pstrb[1:0] == 2'h3)
        begin
            if (hit(paddr, IDX_CHANNEL_COUNTER))
            begin
                st_d.channel_counter = pwdata[15:0];
            end
            if (hit(paddr, IDX_GENERAL_REG_A))
            begin
                st_d.general_reg_a = pwdata[15:0];
            end
            if (hit(paddr, IDX_GENERAL_REG_B))
            begin
                st_d.general_reg_b = pwdata[15:0];
            end
            if (hit(paddr, IDX_GENERAL_REG_C))
            begin
                st_d.general_reg_c = pwdata[15:0];
            end
        end

        // Requests follow the flags that will stand next cycle
        out_d.capture_request_a = flags_next[FLAG_A_BIT] & st_d.request_enable[FLAG_A_BIT];
        out_d.compare_request_c = flags_next[FLAG_C_BIT] & st_d.request_enable[FLAG_C_BIT];
        out_d.irq = |(flags_next & st_d.request_enable);

        // APB: one wait state; read data latched in the first access cycle
        out_d.pready = access & ~out_q.pready;
        out_d.pslverr = access & ~out_q.pready & ~mapped(paddr);
        if (access && !out_q.pready)
        begin
            out_d.prdata = 32'h0000_0000;
            if (hit(paddr, IDX_IO_CONTROL_HIGH))
            begin
                out_d.prdata[7:0] = st_q.io_control_high;
            end
            if (hit(paddr, IDX_CHANNEL_STATUS_FLAGS))
            begin
                out_d.prdata[2:0] = st_q.channel_status_flags;
            end
            if (hit(paddr, IDX_COUNTER_CONTROL))
            begin
                out_d.prdata[7:0] = st_q.counter_control;
            end
            if (hit(paddr, IDX_REQUEST_ENABLE))
            begin
                out_d.prdata[2:0] = st_q.request_enable;
            end
            if (hit(paddr, IDX_CHANNEL_COUNTER))
            begin
                out_d.prdata[15:0] = st_q.channel_counter;
            end
            if (hit(paddr, IDX_GENERAL_REG_A))
            begin
                out_d.prdata[15:0] = st_q.general_reg_a;
            end
            if (hit(paddr, IDX_GENERAL_REG_B))
            begin
                out_d.prdata[15:0] = st_q.general_reg_b;
            end
            if (hit(paddr, IDX_GENERAL_REG_C))
            begin
                out_d.prdata[15:0] = st_q.general_reg_c;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_q <= '{io_control_high: IO_CONTROL_RESET, counter_control: CONTROL_RESET,
                request_enable: ENABLE_RESET, channel_status_flags: 3'h0, read_as_one: 3'h0,
                channel_counter: 16'h0000, general_reg_a: GENERAL_REG_RESET,
                general_reg_b: GENERAL_REG_RESET, general_reg_c: GENERAL_REG_RESET,
                cap_level: 1'b1, pin_b_level: 1'b0};
            out_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            out_q <= out_d;
        end
    end

    assign prdata = out_q.prdata;
    assign pready = out_q.pready;
    assign pslverr = out_q.pslverr;
    assign irq = out_q.irq;
    assign capture_request_a = out_q.capture_request_a;
    assign compare_request_c = out_q.compare_request_c;
    assign capture_compare_pin_b_out = out_q.pin_b_out;
    assign capture_compare_pin_b_oe = out_q.pin_b_oe;
endmodule // tcf_channel

/* verification/tcf_channel_props.sv */
// Port-level assertions of the capture/compare flag channel
`timescale 1ns/1ps
module tcf_channel_props
    import tcf_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic capture_compare_pin_b_in,
    input wire logic capture_compare_pin_b_out,
    input wire logic capture_compare_pin_b_oe,
    input wire logic dma_start_a,
    input wire logic dma_flag_clear_enable,
    input wire logic capture_request_a,
    input wire logic compare_request_c,
    input wire logic irq
);
    localparam logic [31:0] IO_ADDR = {6'h00, IDX_IO_CONTROL_HIGH, 2'h0};
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    chk_bus_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
        else $error("ready without access");
    chk_error_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_irq_any: assert property (capture_request_a || compare_request_c |-> irq)
        else $error("request without interrupt");
    chk_capture_edge: assert property ($rose(capture_request_a) && !$past(pready)
        |-> $past(capture_compare_pin_b_in, 2) && !$past(capture_compare_pin_b_in))
        else $error("capture request without falling edge");
    chk_dma_clear: assert property (dma_start_a && dma_flag_clear_enable
        && capture_compare_pin_b_in && $past(capture_compare_pin_b_in) |=> !capture_request_a)
        else $error("dma start left flag A set");
    chk_pin_b_off: assert property (psel && penable && pready && pwrite && paddr == IO_ADDR
        && pstrb[0] && pwdata[7:4] == 4'h0 |-> ##[1:2] !capture_compare_pin_b_oe)
        else $error("pin B driven with output disabled");
endmodule // tcf_channel_props

bind tcf_channel tcf_channel_props #(.COUNT_WIDTH(COUNT_WIDTH)) u_tcf_channel_props (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_compare_pin_b_in(capture_compare_pin_b_in),
    .capture_compare_pin_b_out(capture_compare_pin_b_out),
    .capture_compare_pin_b_oe(capture_compare_pin_b_oe), .dma_start_a(dma_start_a),
    .dma_flag_clear_enable(dma_flag_clear_enable), .capture_request_a(capture_request_a),
    .compare_request_c(compare_request_c), .irq(irq));

/* verification/tcf_far_side.sv */
// Far side model: capture signal source and DMA controller
`timescale 1ns/1ps
module tcf_far_side
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic fall_cmd,
    input wire logic dma_on,
    input wire logic clear_en,
    input wire logic [1:0] lag,
    input wire logic capture_request_a,
    output logic pin_b,
    output logic dma_start_a,
    output logic dma_flag_clear_enable
);
    logic [1:0] low_q;
    logic [2:0] wait_q;
    logic busy_q;
    // Pin idles high as with a pull-up; a command holds it low two cycles
    assign pin_b = (low_q == 2'h0);
    assign dma_flag_clear_enable = clear_en;
    // One start per request, after a chosen lag, as a slow controller would
    assign dma_start_a = (wait_q == 3'h1);
    always_ff @(posedge core_clk)
    begin
        low_q <= reset ? 2'h0 : fall_cmd ? 2'h2 : (low_q == 2'h0) ? 2'h0 : low_q - 2'h1;
        busy_q <= !reset && capture_request_a && (busy_q || dma_on);
        if (reset || !capture_request_a)
            wait_q <= 3'h0;
        else if (dma_on && !busy_q)
            wait_q <= {1'b0, lag} + 3'h1;
        else if (wait_q != 3'h0)
            wait_q <= wait_q - 3'h1;
    end
endmodule // tcf_far_side

/* verification/tcf_channel_bench.sv */
// Self-checking bench of the capture/compare flag channel
`timescale 1ns/1ps
module tcf_channel_bench;
    import tcf_pkg::*;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err, pin_b, out, oe;
    logic dma_start_a, dte, fall_cmd, dma_on, clear_en, cra, crc, irq;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] lag;
    int n_errors, n_checks, cycles;

    tcf_channel u_tcf_channel (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_compare_pin_b_in(pin_b),
        .capture_compare_pin_b_out(out), .capture_compare_pin_b_oe(oe),
        .dma_start_a(dma_start_a), .dma_flag_clear_enable(dte), .capture_request_a(cra),
        .compare_request_c(crc), .irq(irq));
    tcf_far_side u_tcf_far_side (.core_clk(core_clk), .reset(reset), .fall_cmd(fall_cmd),
        .dma_on(dma_on), .clear_en(clear_en), .lag(lag), .capture_request_a(cra), .pin_b(pin_b),
        .dma_start_a(dma_start_a), .dma_flag_clear_enable(dte));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until ready is sampled; one idle cycle between calls
    task automatic apb(input logic w, input logic [23:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {6'h00, idx, 2'h0};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic fall();
        @(posedge core_clk);
        fall_cmd <= 1'b1;
        @(posedge core_clk);
        fall_cmd <= 1'b0;
        pause(9);
    endtask

    task automatic t_regs();
        apb(0, IDX_IO_CONTROL_HIGH, 0);
        chk(rd, {24'h0, IO_CONTROL_RESET});
        apb(0, 24'h000001, 0);
        chk({31'h0, err}, 32'h1);
        apb(1, IDX_IO_CONTROL_HIGH, 32'h59);
        apb(0, IDX_IO_CONTROL_HIGH, 0);
        chk(rd, 32'h59);
        chk({30'h0, oe, out}, 32'h3);
        apb(1, IDX_IO_CONTROL_HIGH, 32'h09);
        pause(2);
        chk({30'h0, oe, out}, 32'h0);
        // A write without its byte strobe must leave the register alone
        pstrb <= 4'h0;
        apb(1, IDX_IO_CONTROL_HIGH, 32'h59);
        pstrb <= 4'hF;
        apb(0, IDX_IO_CONTROL_HIGH, 0);
        chk(rd, 32'h09);
    endtask

    task automatic t_match_c();
        apb(1, IDX_GENERAL_REG_C, 32'h2);
        apb(1, IDX_COUNTER_CONTROL, 32'h1);
        apb(1, IDX_COUNTER_CONTROL, 32'h0);
        chk({30'h0, crc, irq}, 32'h0);
        apb(1, IDX_REQUEST_ENABLE, 32'h4);
        pause(2);
        chk({30'h0, crc, irq}, 32'h3);
        apb(1, IDX_CHANNEL_STATUS_FLAGS, 0);
        pause(2);
        chk({31'h0, crc}, 32'h1);
        apb(0, IDX_CHANNEL_STATUS_FLAGS, 0);
        chk(rd, 32'h4);
        apb(1, IDX_CHANNEL_STATUS_FLAGS, 0);
        pause(2);
        chk({31'h0, crc}, 32'h0);
        apb(1, IDX_CHANNEL_STATUS_FLAGS, 32'h7);
        apb(0, IDX_CHANNEL_STATUS_FLAGS, 0);
        chk(rd, 32'h0);
    endtask

    task automatic t_capture();
        apb(1, IDX_COUNTER_CONTROL, 32'h20);
        apb(1, IDX_CHANNEL_COUNTER, 32'h1234);
        apb(1, IDX_REQUEST_ENABLE, 32'h1);
        fall();
        chk({30'h0, cra, irq}, 32'h3);
        apb(0, IDX_GENERAL_REG_A, 0);
        chk(rd, 32'h1234);
        apb(0, IDX_CHANNEL_COUNTER, 0);
        chk(rd, 32'h0);
        apb(0, IDX_CHANNEL_STATUS_FLAGS, 0);
        chk(rd, 32'h1);
        apb(1, IDX_CHANNEL_STATUS_FLAGS, 0);
        pause(2);
        chk({31'h0, cra}, 32'h0);
    endtask

    task automatic t_dma();
        dma_on <= 1'b1;
        lag <= 2'h2;
        fall();
        apb(0, IDX_CHANNEL_STATUS_FLAGS, 0);
        chk(rd, 32'h0);
        // Controller still starts, but without clear enable the flag must stay
        clear_en <= 1'b0;
        fall();
        apb(1, IDX_REQUEST_ENABLE, 0);
        pause(2);
        chk({30'h0, cra, irq}, 32'h0);
        apb(0, IDX_CHANNEL_STATUS_FLAGS, 0);
        chk(rd, 32'h1);
    endtask

    task automatic end_of_test();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // A hang counts as a mismatch
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    initial
    begin
        {reset, psel, penable, pwrite, fall_cmd, dma_on} = 6'h20;
        {paddr, pwdata, lag, pstrb} = {64'h0, 2'h0, 4'hF};
        clear_en = 1'b1;
        pause(6);
        reset <= 1'b0;
        t_regs();
        t_match_c();
        t_capture();
        t_dma();
        end_of_test();
    end
endmodule // tcf_channel_bench
